// file: rtl/jdp_port.sv
// Contract
// RULE1 - All test logic steps on external test clock.
// RULE2 - Take data-in bit on clock rising edge.
// RULE3 - Drive data-out only in shift states.
// RULE4 - Change data-out on clock falling edge.
// RULE5 - Test reset low resets controller, clock-free.
// RULE6 - Host holds test reset low with device reset.
// RULE7 - Device reset leaves test port state intact.
// RULE8 - Debug event gives one low pulse.
// RULE9 - Mode select sampled on rising edge, sixteen states.
// RULE10 - Five high mode-select edges reach reset state.
`timescale 1ns/1ps
`default_nettype none

module jdp_port #(
    parameter int IR_W      = jdp_pkg::IR_WIDTH,
    parameter int PULSE_CYC = jdp_pkg::EVENT_PULSE_CYC
) (
    input  wire logic            REF_CLK_IN,
    input  wire logic            RST_N_IN,
    input  wire logic            TCK_IN,
    input  wire logic            TMS_IN,
    input  wire logic            TDI_IN,
    input  wire logic            TRST_N_IN,
    input  wire logic            DEBUG_HIT_IN,
    output var  logic            TDO_OUT,
    output var  logic            TDO_OE_OUT,
    output var  logic            DEBUG_EVENT_N_OUT,
    output var  logic [IR_W-1:0] IR_OUT
);

    logic [2:0]             pin_s;
    logic                   tck_s;
    logic                   tms_s;
    logic                   tdi_s;
    logic                   tap_rst_n;
    logic                   tck_d_q;
    logic                   tck_rise;
    logic                   tck_fall;
    jdp_pkg::jdp_tap_state_t state_q;
    jdp_pkg::jdp_tap_state_t state_d;
    logic [IR_W-1:0]        ir_sh_q;
    logic                   bypass_q;
    logic [7:0]             pulse_cnt_q;

    // Test clock, mode select and data in cross together so they stay aligned.
    // The stages belong to the test port, not the device, so a device reset
    // taken with the test clock high cannot fake an edge when it lets go.
    jdp_sync #(.W(3)) u_pin_sync (
        .clk_in   (REF_CLK_IN),
        .rst_n_in (tap_rst_n), // RULE7
        .d_in     ({TCK_IN, TMS_IN, TDI_IN}),
        .q_out    (pin_s)
    );

    assign tck_s = pin_s[2];
    assign tms_s = pin_s[1];
    assign tdi_s = pin_s[0];

    // Test reset asserts immediately, with or without a test clock, and releases
    // synchronously. The device reset is kept out of it on purpose.
    // A test clock already high at release shows as one rising edge; with mode
    // select held high that edge leaves the controller in its reset state.
    jdp_sync #(.W(1)) u_trst_sync (
        .clk_in   (REF_CLK_IN),
        .rst_n_in (TRST_N_IN), // RULE5
        .d_in     (1'b1),
        .q_out    (tap_rst_n)
    );

    always_ff @(posedge REF_CLK_IN or negedge tap_rst_n) begin
        if (!tap_rst_n) begin
            tck_d_q <= 1'b0;
        end else begin
            tck_d_q <= tck_s;
        end
    end

    // Every test-side step is gated by an edge found on the test clock.
    assign tck_rise = tck_s & ~tck_d_q; // RULE1
    assign tck_fall = ~tck_s & tck_d_q; // RULE1

    function automatic jdp_pkg::jdp_tap_state_t tap_next(
        input jdp_pkg::jdp_tap_state_t s,
        input logic                    tms
    );
        case (s)
            jdp_pkg::TAP_RESET:    tap_next = tms ? jdp_pkg::TAP_RESET   : jdp_pkg::TAP_IDLE;
            jdp_pkg::TAP_IDLE:     tap_next = tms ? jdp_pkg::TAP_SEL_DR  : jdp_pkg::TAP_IDLE;
            jdp_pkg::TAP_SEL_DR:   tap_next = tms ? jdp_pkg::TAP_SEL_IR  : jdp_pkg::TAP_CAP_DR;
            jdp_pkg::TAP_CAP_DR:   tap_next = tms ? jdp_pkg::TAP_EXIT1_DR : jdp_pkg::TAP_SHIFT_DR;
            jdp_pkg::TAP_SHIFT_DR: tap_next = tms ? jdp_pkg::TAP_EXIT1_DR : jdp_pkg::TAP_SHIFT_DR;
            jdp_pkg::TAP_EXIT1_DR: tap_next = tms ? jdp_pkg::TAP_UPD_DR  : jdp_pkg::TAP_PAUSE_DR;
            jdp_pkg::TAP_PAUSE_DR: tap_next = tms ? jdp_pkg::TAP_EXIT2_DR : jdp_pkg::TAP_PAUSE_DR;
            jdp_pkg::TAP_EXIT2_DR: tap_next = tms ? jdp_pkg::TAP_UPD_DR  : jdp_pkg::TAP_SHIFT_DR;
            jdp_pkg::TAP_UPD_DR:   tap_next = tms ? jdp_pkg::TAP_SEL_DR  : jdp_pkg::TAP_IDLE;
            jdp_pkg::TAP_SEL_IR:   tap_next = tms ? jdp_pkg::TAP_RESET   : jdp_pkg::TAP_CAP_IR;
            jdp_pkg::TAP_CAP_IR:   tap_next = tms ? jdp_pkg::TAP_EXIT1_IR : jdp_pkg::TAP_SHIFT_IR;
            jdp_pkg::TAP_SHIFT_IR: tap_next = tms ? jdp_pkg::TAP_EXIT1_IR : jdp_pkg::TAP_SHIFT_IR;
            jdp_pkg::TAP_EXIT1_IR: tap_next = tms ? jdp_pkg::TAP_UPD_IR  : jdp_pkg::TAP_PAUSE_IR;
            jdp_pkg::TAP_PAUSE_IR: tap_next = tms ? jdp_pkg::TAP_EXIT2_IR : jdp_pkg::TAP_PAUSE_IR;
            jdp_pkg::TAP_EXIT2_IR: tap_next = tms ? jdp_pkg::TAP_UPD_IR  : jdp_pkg::TAP_SHIFT_IR;
            jdp_pkg::TAP_UPD_IR:   tap_next = tms ? jdp_pkg::TAP_SEL_DR  : jdp_pkg::TAP_IDLE;
            default:               tap_next = jdp_pkg::TAP_RESET;
        endcase
    endfunction

    // From any state, five high mode-select edges end in the reset state.
    always_comb begin
        state_d = state_q;
        if (tck_rise) begin
            state_d = tap_next(state_q, tms_s); // RULE9 RULE10
        end
    end

    // Only the test reset clears the controller, so a device reset during
    // debugging leaves the session where it was.
    always_ff @(posedge REF_CLK_IN or negedge tap_rst_n) begin
        if (!tap_rst_n) begin
            state_q <= jdp_pkg::TAP_RESET; // RULE5 RULE7
        end else begin
            state_q <= state_d; // RULE9
        end
    end

    // Instruction path: capture a fixed pattern, shift, then update.
    always_ff @(posedge REF_CLK_IN or negedge tap_rst_n) begin
        if (!tap_rst_n) begin
            ir_sh_q <= IR_W'(jdp_pkg::IR_RESET_VALUE);
            IR_OUT  <= IR_W'(jdp_pkg::IR_RESET_VALUE);
        end else if (tck_rise) begin
            case (state_q)
                jdp_pkg::TAP_RESET: begin
                    IR_OUT <= IR_W'(jdp_pkg::IR_RESET_VALUE);
                end
                jdp_pkg::TAP_CAP_IR: begin
                    ir_sh_q <= IR_W'(jdp_pkg::IR_CAPTURE_VALUE);
                end
                jdp_pkg::TAP_SHIFT_IR: begin
                    ir_sh_q <= {tdi_s, ir_sh_q[IR_W-1:1]}; // RULE2
                end
                jdp_pkg::TAP_UPD_IR: begin
                    IR_OUT <= ir_sh_q;
                end
                default: begin
                    ir_sh_q <= ir_sh_q;
                end
            endcase
        end
    end

    // Data path is the one-bit bypass stage; richer data registers hang here.
    always_ff @(posedge REF_CLK_IN or negedge tap_rst_n) begin
        if (!tap_rst_n) begin
            bypass_q <= 1'b0;
        end else if (tck_rise) begin
            if (state_q == jdp_pkg::TAP_CAP_DR) begin
                bypass_q <= 1'b0;
            end else if (state_q == jdp_pkg::TAP_SHIFT_DR) begin
                bypass_q <= tdi_s; // RULE2
            end
        end
    end

    // Only the two shift states own the output pin.
    function automatic logic in_shift(input jdp_pkg::jdp_tap_state_t s);
        return (s == jdp_pkg::TAP_SHIFT_IR) || (s == jdp_pkg::TAP_SHIFT_DR);
    endfunction

    // Serial bit for the present state; zero whenever the pin is released.
    function automatic logic shift_bit(
        input jdp_pkg::jdp_tap_state_t s,
        input logic                    ir_bit,
        input logic                    dr_bit
    );
        case (s)
            jdp_pkg::TAP_SHIFT_IR: shift_bit = ir_bit;
            jdp_pkg::TAP_SHIFT_DR: shift_bit = dr_bit;
            default:               shift_bit = 1'b0;
        endcase
    endfunction

    // Output changes on the falling edge so the host samples a settled bit on
    // the next rising edge.
    always_ff @(posedge REF_CLK_IN or negedge tap_rst_n) begin
        if (!tap_rst_n) begin
            TDO_OUT <= 1'b0;
        end else if (tck_fall) begin // RULE4
            TDO_OUT <= shift_bit(state_q, ir_sh_q[0], bypass_q);
        end
    end

    // The enable follows the state at that same falling edge.
    always_ff @(posedge REF_CLK_IN or negedge tap_rst_n) begin
        if (!tap_rst_n) begin
            TDO_OE_OUT <= 1'b0; // RULE3
        end else if (tck_fall) begin // RULE4
            TDO_OE_OUT <= in_shift(state_q); // RULE3
        end
    end

    // The pulse belongs to the debug logic, so the device reset governs it and
    // the test reset leaves it alone.
    // A new hit during a pulse restarts it rather than being lost.
    always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            pulse_cnt_q       <= jdp_pkg::EVENT_CNT_RESET;
            DEBUG_EVENT_N_OUT <= 1'b1;
        end else if (DEBUG_HIT_IN) begin
            pulse_cnt_q       <= 8'(PULSE_CYC - 1);
            DEBUG_EVENT_N_OUT <= 1'b0; // RULE8
        end else if (pulse_cnt_q != 8'h00) begin
            pulse_cnt_q       <= pulse_cnt_q - 8'h01;
            DEBUG_EVENT_N_OUT <= 1'b0;
        end else begin
            DEBUG_EVENT_N_OUT <= 1'b1; // RULE8
        end
    end

endmodule // jdp_port

`default_nettype wire

// file: rtl/jdp_pkg.sv
package jdp_pkg;

    typedef enum logic [3:0] {
        TAP_RESET,
        TAP_IDLE,
        TAP_SEL_DR,
        TAP_CAP_DR,
        TAP_SHIFT_DR,
        TAP_EXIT1_DR,
        TAP_PAUSE_DR,
        TAP_EXIT2_DR,
        TAP_UPD_DR,
        TAP_SEL_IR,
        TAP_CAP_IR,
        TAP_SHIFT_IR,
        TAP_EXIT1_IR,
        TAP_PAUSE_IR,
        TAP_EXIT2_IR,
        TAP_UPD_IR
    } jdp_tap_state_t;

    localparam int          IR_WIDTH          = 4;
    localparam logic [3:0]  IR_CAPTURE_VALUE  = 4'h1;
    localparam logic [3:0]  IR_RESET_VALUE    = 4'hf;
    localparam int          REF_CLK_PERIOD_PS = 4000;
    localparam int          EVENT_PULSE_NS    = 20;
    localparam int          EVENT_PULSE_CYC   =
        (EVENT_PULSE_NS * 1000 + REF_CLK_PERIOD_PS - 1) / REF_CLK_PERIOD_PS;
    localparam logic [7:0]  EVENT_CNT_RESET   = 8'h00;

endpackage

// file: rtl/jdp_sync.sv
`timescale 1ns/1ps
`default_nettype none

module jdp_sync #(
    parameter int W = 1
) (
    input  wire logic         clk_in,
    input  wire logic         rst_n_in,
    input  wire logic [W-1:0] d_in,
    output var  logic [W-1:0] q_out
);

    logic [W-1:0] meta_q;

    // The first stage is only ever read by the second.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            meta_q <= '0;
            q_out  <= '0;
        end else begin
            meta_q <= d_in;
            q_out  <= meta_q;
        end
    end

endmodule // jdp_sync

`default_nettype wire

// file: tb/jdp_chk.sv
`timescale 1ns/1ps
`default_nettype none
module jdp_chk #(
    parameter int IR_W      = 4,
    parameter int PULSE_CYC = 5
) (
    input wire logic            REF_CLK_IN,
    input wire logic            RST_N_IN,
    input wire logic            TCK_IN,
    input wire logic            TRST_N_IN,
    input wire logic            DEBUG_HIT_IN,
    input wire logic            TDO_OUT,
    input wire logic            TDO_OE_OUT,
    input wire logic            DEBUG_EVENT_N_OUT,
    input wire logic [IR_W-1:0] IR_OUT
);
    default clocking @(posedge REF_CLK_IN); endclocking
    default disable iff (!TRST_N_IN);
    // Test reset seen low at the last edge too; the first edge has no history.
    logic trst_low_q = 1'b0;
    always_ff @(posedge REF_CLK_IN) begin
        trst_low_q <= !TRST_N_IN;
    end
    // The counts of 5 stand for PULSE_CYC; a repetition must be a literal.
    property p_ev_low;
        disable iff (!RST_N_IN) DEBUG_HIT_IN |=> !DEBUG_EVENT_N_OUT [*5];
    endproperty
    a_ev_low: assert property (p_ev_low) else $error("pulse short");
    property p_ev_end;
        disable iff (!RST_N_IN) DEBUG_HIT_IN ##1 !DEBUG_HIT_IN [*5] |=> DEBUG_EVENT_N_OUT;
    endproperty
    a_ev_end: assert property (p_ev_end) else $error("pulse long");
    property p_ev_cause;
        disable iff (!RST_N_IN) $fell(DEBUG_EVENT_N_OUT) |-> $past(DEBUG_HIT_IN);
    endproperty
    a_ev_cause: assert property (p_ev_cause) else $error("pulse uncaused");
    property p_trst;
        disable iff (1'b0) !TRST_N_IN && trst_low_q |-> !TDO_OE_OUT && IR_OUT == 4'hf;
    endproperty
    a_trst: assert property (p_trst) else $error("test reset ignored");
    property p_fall; $changed(TDO_OUT) || $changed(TDO_OE_OUT) |-> !$past(TCK_IN, 2); endproperty
    a_fall: assert property (p_fall) else $error("data out moved off fall");
    property p_rise; $changed(IR_OUT) |-> $past(TCK_IN, 2); endproperty
    a_rise: assert property (p_rise) else $error("instruction moved off rise");
    property p_oe_hold; $rose(TDO_OE_OUT) |-> TDO_OE_OUT [*6]; endproperty
    a_oe_hold: assert property (p_oe_hold) else $error("drive too short");
    property p_keep; $fell(RST_N_IN) |-> $stable(IR_OUT) && $stable(TDO_OE_OUT); endproperty
    a_keep: assert property (p_keep) else $error("device reset hit port");
    property p_quiet;
        (TCK_IN == $past(TCK_IN)) [*8] |-> $stable(TDO_OUT) && $stable(IR_OUT);
    endproperty
    a_quiet: assert property (p_quiet) else $error("moved without clock");
    c_b2b: cover property (DEBUG_HIT_IN ##1 DEBUG_HIT_IN);
    c_shift: cover property ($rose(TDO_OE_OUT));
    c_keep: cover property ($fell(RST_N_IN) && TDO_OE_OUT);
endmodule // jdp_chk
`default_nettype wire

// file: tb/jdp_host.sv
`timescale 1ns/1ps
`default_nettype none
// The test clock stands low between steps; data-in falls back to its pull-up level.
module jdp_host (
    input  wire logic clk_in,
    input  wire logic tdo_in,
    output var  logic tck_out,
    output var  logic tms_out,
    output var  logic tdi_out
);
    initial begin
        tck_out = 1'b0;
        tms_out = 1'b1;
        tdi_out = 1'b1;
    end
    task automatic step(input logic m, input logic d, output logic o);
        @(negedge clk_in);
        tms_out = m;
        tdi_out = d;
        repeat (3) @(negedge clk_in);
        tck_out = 1'b1;
        o = tdo_in;
        repeat (4) @(negedge clk_in);
        tck_out = 1'b0;
        tdi_out = 1'b1;
    endtask
endmodule // jdp_host
`default_nettype wire

// file: tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam int PC = 5;
    logic       clk = 1'b0, rst_n = 1'b0, trst_n = 1'b0, hit = 1'b0;
    logic       tdo, oe, ev_n, o;
    wire logic  tck, tms, tdi;
    logic [3:0] ir, e;
    int         fails = 0, comparisons = 0, cyc = 0, seed = 5, g, n;
    wire logic  tdo_pin = oe ? tdo : 1'bz;
    always #2 clk = ~clk;
    jdp_host jdp_host_inst (.clk_in(clk), .tdo_in(tdo_pin), .tck_out(tck), .tms_out(tms),
        .tdi_out(tdi));
    jdp_port #(.IR_W(4), .PULSE_CYC(PC)) jdp_port_inst (.REF_CLK_IN(clk), .RST_N_IN(rst_n),
        .TCK_IN(tck), .TMS_IN(tms), .TDI_IN(tdi), .TRST_N_IN(trst_n), .DEBUG_HIT_IN(hit),
        .TDO_OUT(tdo), .TDO_OE_OUT(oe), .DEBUG_EVENT_N_OUT(ev_n), .IR_OUT(ir));
    task automatic test_done;
        if (fails == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic cmp_ir(input logic [3:0] got, input logic [3:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp_bit(input logic got, input logic exp);
        cmp_ir({3'h0, got}, {3'h0, exp});
    endtask
    task automatic walk(input logic [7:0] m, input int k);
        for (int i = 0; i < k; i++) jdp_host_inst.step(m[i], 1'b1, o);
    endtask
    task automatic shift(input logic [3:0] d, input int k, output logic [3:0] q);
        q = 4'h0;
        for (int i = 0; i < k; i++) begin
            jdp_host_inst.step(i == k - 1, d[i], o);
            q[i] = o;
        end
    endtask
    // A bypass stage first shows its captured zero, then the bits fed in.
    function automatic logic [3:0] byp(input logic [3:0] d);
        return {1'b0, d[1:0], 1'b0};
    endfunction
    function automatic logic [3:0] exp_low(input int gap);
        return 4'(gap + PC);
    endfunction
    always @(posedge clk) begin
        cyc++;
        if (cyc > 5000) begin
            fails++;
            test_done();
        end
    end
    initial begin
        logic [3:0] v;
        repeat (16) @(negedge clk);
        rst_n = 1'b1;
        trst_n = 1'b1;
        cmp_ir(ir, 4'hf);
        repeat (4) @(negedge clk);
        for (int t = 0; t < 3; t++) begin
            v = 4'($random(seed));
            walk(8'h06, 5);
            shift(v, 4, e);
            cmp_ir(e, 4'h1);
            walk(8'h01, 2);
            cmp_ir(ir, v);
            cmp_bit(oe, 1'b0);
            walk(8'h01, 3);
            shift(v, 3, e);
            cmp_ir(e, byp(v));
            walk(8'h01, 2);
        end
        walk(8'h06, 5);
        repeat (4) @(negedge clk);
        rst_n = 1'b0;
        repeat (4) @(negedge clk);
        cmp_bit(oe, 1'b1);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        shift(4'h5, 4, e);
        cmp_ir(e, 4'h1);
        walk(8'h01, 5);
        cmp_ir(ir, 4'h5);
        // From a paused data path only the fifth high reaches reset; the low
        // step after it loads the reset instruction.
        walk(8'h05, 4);
        walk(8'h1f, 6);
        cmp_ir(ir, 4'hf);
        walk(8'h06, 5);
        repeat (4) @(negedge clk);
        trst_n = 1'b0;
        repeat (4) @(negedge clk);
        cmp_bit(oe, 1'b0);
        trst_n = 1'b1;
        repeat (4) @(negedge clk);
        for (int t = 0; t < 6; t++) begin
            g = (t == 0) ? 1 : 1 + int'($unsigned($random(seed)) % 3);
            n = 0;
            for (int k = 0; k < 30; k++) begin
                hit = (k == 0 || k == g);
                @(negedge clk);
                n += int'(ev_n === 1'b0);
            end
            cmp_ir(4'(n), exp_low(g));
        end
        test_done();
    end
endmodule // tb
bind jdp_port jdp_chk #(.IR_W(IR_W), .PULSE_CYC(PULSE_CYC)) jdp_chk_inst (
    .REF_CLK_IN(REF_CLK_IN), .RST_N_IN(RST_N_IN), .TCK_IN(TCK_IN), .TRST_N_IN(TRST_N_IN),
    .DEBUG_HIT_IN(DEBUG_HIT_IN), .TDO_OUT(TDO_OUT), .TDO_OE_OUT(TDO_OE_OUT),
    .DEBUG_EVENT_N_OUT(DEBUG_EVENT_N_OUT), .IR_OUT(IR_OUT));
`default_nettype wire
